// ---- core/ssb_pkg.sv ----
// package: constants, register map and types of the stream source burst block
package ssb_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_ERR_STAT = 12'h008;
    localparam logic [11:0] REG_ERR_EN   = 12'h00c;
    localparam logic [11:0] REG_TAGS     = 12'h010;
    localparam logic [11:0] REG_BURSTS   = 12'h014;
    // ctrl field positions
    localparam int CTRL_LINK_UP   = 0;
    localparam int CTRL_BURST_MD  = 1;
    localparam int CTRL_ECC_EN    = 2;
    localparam int CTRL_CRC_INJ   = 3;
    localparam int CTRL_GAP_LSB   = 8;
    localparam int CTRL_GAP_W     = 8;
    // reset values
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [3:0]  ERR_EN_RST   = 4'h0;
    // error vector bits
    localparam int ERR_OVF   = 0;
    localparam int ERR_SEU_C = 1;
    localparam int ERR_SEU_U = 2;
    localparam int ERR_GAP   = 3;
    localparam int ERR_W     = 4;
    // widths and fifo levels
    localparam int DATA_W    = 64;
    localparam int TAG_W     = 8;
    localparam int FIFO_DEP  = 16;
    localparam int FIFO_AW   = 4;
    localparam logic [FIFO_AW:0] FIFO_PFULL = 5'h0c;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
    localparam logic [31:0] CRC_FLIP = 32'h0000_0001;
    localparam logic [TAG_W-1:0] GAP_RST = 8'h00;
    // burst tracking states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BURST = 3'b010,
        ST_GAP   = 3'b100
    } ssb_state_t;
endpackage

// ---- core/ssb_fifo_if.sv ----
// interface: handshake between the framer and its adaptation fifo
`timescale 1ns/10ps
`default_nettype none
interface ssb_fifo_if;
    import ssb_pkg::*;
    logic                 wr_en;
    logic [DATA_W+1:0]    wr_data;
    logic                 rd_en;
    logic [DATA_W+1:0]    rd_data;
    logic                 empty;
    logic                 overflow;
    logic [FIFO_AW:0]     level;
    modport owner (output wr_en, output wr_data, output rd_en,
                   input rd_data, input empty, input overflow, input level);
    modport fifo  (input wr_en, input wr_data, input rd_en,
                   output rd_data, output empty, output overflow,
                   output level);
endinterface
`default_nettype wire

// ---- core/ssb_fifo.sv ----
// adaptation fifo with overflow flag and fill level
`timescale 1ns/10ps
`default_nettype none
module ssb_fifo
    import ssb_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    ssb_fifo_if.fifo   fif
);
    logic [DATA_W+1:0] mem [FIFO_DEP];
    logic [FIFO_AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [FIFO_AW:0]   cnt_ff, nxt_cnt;
    logic               ovf_ff, nxt_ovf;
    logic               do_wr, do_rd;

    // ---------------------------------------------------------------
    // pointer and count update
    // ---------------------------------------------------------------
    // a write into a full fifo with no read in the same cycle is dropped and flagged for one cycle
    always_comb begin
        do_rd   = fif.rd_en && (cnt_ff != '0);
        do_wr   = fif.wr_en && (cnt_ff != FIFO_DEP[FIFO_AW:0] || do_rd);
        nxt_ovf = fif.wr_en && !do_wr;
        nxt_wp  = do_wr ? wp_ff + 1'b1 : wp_ff;
        nxt_rp  = do_rd ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + {{FIFO_AW{1'b0}}, do_wr}
                         - {{FIFO_AW{1'b0}}, do_rd};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
            ovf_ff <= nxt_ovf;
        end
    end

    // storage has no reset; contents are qualified by count
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_ff] <= fif.wr_data;
        end
    end

    assign fif.rd_data  = mem[rp_ff];
    assign fif.empty    = (cnt_ff == '0);
    assign fif.overflow = ovf_ff;
    assign fif.level    = cnt_ff;
endmodule
`default_nettype wire

// ---- core/ssb_source.sv ----
// stream source burst interface: user side of the transmit core
// ---------------------------------------------------------------
// Functional notes
// RQ1 - continuous mode: user raises burst begin once, on the first word
// RQ2 - burst mode: user marks last word of burst with burst end
// RQ3 - continuous mode: burst end at close is optional; core accepts both
// RQ4 - 4-bit error vector; bit 0 flags adaptation fifo overflow
// RQ5 - bit 1 flags corrected upset when ecc enabled, else meaningless
// RQ6 - bit 2 flags uncorrectable upset when ecc enabled, else meaningless
// RQ7 - bit 3 flags idle gap between bursts not matching set gap
// RQ8 - injection input, when enabled, corrupts transmitted crc-32 values
// RQ9 - interrupt rises when any status bit and its enable are set
// RQ10 - interrupt falls only once every enabled status bit is cleared
// RQ11 - burst mode: user marks first word of a burst with burst begin
// RQ12 - 8-bit tag sampled at burst begin and end, carried over link
// RQ13 - ready low after reset until link up; low on loss or partial full
// RQ14 - link-ready output only once initialization finished
// RQ15 - user keeps valid high whenever a burst flag is high
// RQ16 - error bits synchronous, high at least one cycle per event
// ---------------------------------------------------------------
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ssb_source
    import ssb_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // user stream
    input  wire logic [DATA_W-1:0] DATA,
    input  wire logic [TAG_W-1:0]  SYNC,
    input  wire logic              VALID,
    input  wire logic              BURST_BEGIN_FLAG,
    input  wire logic              BURST_END_FLAG,
    input  wire logic              CRC_ERROR_INJECT,
    input  wire logic              SEU_CORRECTED,
    input  wire logic              SEU_UNCORRECTED,
    output logic                   READY,
    output logic                   LINK_UP,
    output logic      [ERR_W-1:0]  ERROR,
    output logic                   ERR_INTERRUPT,
    // link side
    input  wire logic              LINK_TAKE,
    output logic      [DATA_W-1:0] LINK_DATA,
    output logic      [TAG_W-1:0]  LINK_TAG,
    output logic                   LINK_BEGIN,
    output logic                   LINK_END,
    output logic                   LINK_VALID,
    output logic      [31:0]       LINK_CRC
);
    // ---------------------------------------------------------------
    // crc-32 step over one 64-bit word, used for running check value
    // ---------------------------------------------------------------
    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [63:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 63; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    ssb_fifo_if fif ();
    ssb_fifo u_fifo (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .fif   (fif.fifo)
    );

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [31:0]      ctrl_ff, nxt_ctrl;
    logic [ERR_W-1:0] stat_ff, nxt_stat;
    logic [ERR_W-1:0] en_ff, nxt_en;
    logic [31:0]      rdata_ff, nxt_rdata;
    logic             slverr_ff, nxt_slverr;
    logic [ERR_W-1:0] err_ev;
    logic             wr_acc, rd_acc, addr_ok;
    logic             burst_md, ecc_en, crc_inj_en;
    logic [TAG_W-1:0] gap_cfg;

    assign burst_md   = ctrl_ff[CTRL_BURST_MD];
    assign ecc_en     = ctrl_ff[CTRL_ECC_EN];
    assign crc_inj_en = ctrl_ff[CTRL_CRC_INJ];
    assign gap_cfg    = ctrl_ff[CTRL_GAP_LSB +: CTRL_GAP_W];
    assign wr_acc     = PSEL && PENABLE && PWRITE;
    assign rd_acc     = PSEL && !PENABLE && !PWRITE;
    assign addr_ok    = (PADDR == REG_CTRL) || (PADDR == REG_STATUS)
                     || (PADDR == REG_ERR_STAT) || (PADDR == REG_ERR_EN)
                     || (PADDR == REG_TAGS) || (PADDR == REG_BURSTS);

    // ---------------------------------------------------------------
    // stream and burst tracking state
    // ---------------------------------------------------------------
    ssb_state_t       st_ff, nxt_st;
    logic [TAG_W-1:0] gap_ff, nxt_gap;
    logic [TAG_W-1:0] tag_b_ff, nxt_tag_b, tag_e_ff, nxt_tag_e;
    logic [15:0]      nburst_ff, nxt_nburst;
    logic [ERR_W-1:0] errout_ff, nxt_errout;
    logic [31:0]      crc_ff, nxt_crc;
    logic [DATA_W-1:0] ldata_ff, nxt_ldata;
    logic [TAG_W-1:0] ltag_ff, nxt_ltag;
    logic [1:0]       lflag_ff, nxt_lflag;
    logic             lvalid_ff, nxt_lvalid;
    logic             lup_ff, nxt_lup;
    logic             accept, take;

    // words are taken only while ready is shown; others are ignored
    assign accept = VALID && READY;
    assign take   = !fif.empty && LINK_TAKE && !lvalid_ff;

    // ready waits for link up and backs off at partial full
    assign READY = lup_ff && RST_N && (fif.level < FIFO_PFULL); // RQ13
    assign fif.wr_en   = accept;
    assign fif.wr_data = {BURST_BEGIN_FLAG, BURST_END_FLAG, DATA};
    assign fif.rd_en   = take;

    // ---------------------------------------------------------------
    // error events
    // ---------------------------------------------------------------
    // upset inputs mean nothing without ecc, so they are masked
    always_comb begin
        err_ev            = '0;
        err_ev[ERR_OVF]   = fif.overflow;                  // RQ4
        err_ev[ERR_SEU_C] = ecc_en && SEU_CORRECTED;       // RQ5
        err_ev[ERR_SEU_U] = ecc_en && SEU_UNCORRECTED;     // RQ6
        err_ev[ERR_GAP]   = accept && BURST_BEGIN_FLAG && burst_md
                         && (st_ff == ST_GAP) && (gap_ff != gap_cfg); // RQ7
    end

    // ---------------------------------------------------------------
    // burst tracker, tags, link output stage and crc next values
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st     = st_ff;
        nxt_gap    = gap_ff;
        nxt_tag_b  = tag_b_ff;
        nxt_tag_e  = tag_e_ff;
        nxt_nburst = nburst_ff;
        nxt_errout = err_ev;                               // RQ16
        nxt_crc    = crc_ff;
        nxt_ldata  = ldata_ff;
        nxt_ltag   = ltag_ff;
        nxt_lflag  = 2'b00;
        nxt_lvalid = 1'b0;
        nxt_lup    = ctrl_ff[CTRL_LINK_UP];                // RQ14
        // gap counts idle cycles after an end; saturates
        if (st_ff == ST_GAP && gap_ff != {TAG_W{1'b1}}) begin
            nxt_gap = gap_ff + 1'b1;
        end
        if (accept && BURST_BEGIN_FLAG) begin
            nxt_tag_b  = SYNC;                             // RQ12
            nxt_nburst = nburst_ff + 1'b1;
            nxt_st     = ST_BURST;
        end
        // end is optional in continuous mode; both forms are legal
        if (accept && BURST_END_FLAG) begin
            nxt_tag_e = SYNC;                              // RQ12 RQ3
            nxt_st    = ST_GAP;
            nxt_gap   = GAP_RST;
        end
        if (take) begin
            nxt_ldata  = fif.rd_data[DATA_W-1:0];
            nxt_lflag  = fif.rd_data[DATA_W+1:DATA_W];
            nxt_lvalid = 1'b1;
            nxt_ltag   = fif.rd_data[DATA_W+1] ? tag_b_ff : tag_e_ff;
            nxt_crc    = crc_step(fif.rd_data[DATA_W+1] ? CRC_INIT : crc_ff,
                                  fif.rd_data[DATA_W-1:0]);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_ff     <= ST_IDLE;
            gap_ff    <= GAP_RST;
            tag_b_ff  <= '0;
            tag_e_ff  <= '0;
            nburst_ff <= '0;
            errout_ff <= '0;
            crc_ff    <= CRC_INIT;
            ldata_ff  <= '0;
            ltag_ff   <= '0;
            lflag_ff  <= 2'b00;
            lvalid_ff <= 1'b0;
            lup_ff    <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            gap_ff    <= nxt_gap;
            tag_b_ff  <= nxt_tag_b;
            tag_e_ff  <= nxt_tag_e;
            nburst_ff <= nxt_nburst;
            errout_ff <= nxt_errout;
            crc_ff    <= nxt_crc;
            ldata_ff  <= nxt_ldata;
            ltag_ff   <= nxt_ltag;
            lflag_ff  <= nxt_lflag;
            lvalid_ff <= nxt_lvalid;
            lup_ff    <= nxt_lup;
        end
    end

    // check value flipped while injection is armed and requested
    assign LINK_CRC   = (crc_inj_en && CRC_ERROR_INJECT)
                      ? (crc_ff ^ CRC_FLIP) : crc_ff;      // RQ8
    assign LINK_DATA  = ldata_ff;
    assign LINK_TAG   = ltag_ff;
    assign LINK_BEGIN = lflag_ff[1];
    assign LINK_END   = lflag_ff[0];
    assign LINK_VALID = lvalid_ff;
    assign LINK_UP    = lup_ff;                            // RQ14
    assign ERROR      = errout_ff;                         // RQ4

    // ---------------------------------------------------------------
    // apb register next values; sticky bits set wins over clear
    // ---------------------------------------------------------------
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_en     = en_ff;
        nxt_stat   = stat_ff;
        nxt_rdata  = rdata_ff;
        nxt_slverr = 1'b0;
        if (wr_acc && PADDR == REG_CTRL) begin
            nxt_ctrl = PWDATA;
        end else if (wr_acc && PADDR == REG_ERR_EN) begin
            nxt_en = PWDATA[ERR_W-1:0];
        end else if (wr_acc && PADDR == REG_ERR_STAT) begin
            nxt_stat = stat_ff & ~PWDATA[ERR_W-1:0];       // RQ10
        end
        nxt_stat = nxt_stat | err_ev;
        // read data captured in setup so it is registered at access
        if (rd_acc) begin
            if (PADDR == REG_CTRL) begin
                nxt_rdata = ctrl_ff;
            end else if (PADDR == REG_STATUS) begin
                nxt_rdata = {26'h0, st_ff, fif.empty, READY, lup_ff};
            end else if (PADDR == REG_ERR_STAT) begin
                nxt_rdata = {28'h0, stat_ff};
            end else if (PADDR == REG_ERR_EN) begin
                nxt_rdata = {28'h0, en_ff};
            end else if (PADDR == REG_TAGS) begin
                nxt_rdata = {16'h0, tag_e_ff, tag_b_ff};
            end else if (PADDR == REG_BURSTS) begin
                nxt_rdata = {16'h0, nburst_ff};
            end else begin
                nxt_rdata = 32'h0;
            end
        end
        if (PSEL && !PENABLE) begin
            nxt_slverr = !addr_ok;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_ff   <= CTRL_RST;
            en_ff     <= ERR_EN_RST;
            stat_ff   <= '0;
            rdata_ff  <= '0;
            slverr_ff <= 1'b0;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            en_ff     <= nxt_en;
            stat_ff   <= nxt_stat;
            rdata_ff  <= nxt_rdata;
            slverr_ff <= nxt_slverr;
        end
    end

    assign PRDATA        = rdata_ff;
    assign PREADY        = 1'b1;
    assign PSLVERR       = PSEL && PENABLE && slverr_ff;
    assign ERR_INTERRUPT = |(stat_ff & en_ff);             // RQ9 RQ10
endmodule
`default_nettype wire

// ---- tb/ssb_user_model.sv ----
// model of the user logic that feeds bursts into the source core
`timescale 1ns/10ps
`default_nettype none
module ssb_user_model
    import ssb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire logic [7:0]        len,
    input  wire logic [TAG_W-1:0]  tag,
    input  wire logic              ready,
    output logic      [DATA_W-1:0] data = '0,
    output logic      [TAG_W-1:0]  sync = '0,
    output logic                   valid = 1'b0,
    output logic                   begin_f = 1'b0,
    output logic                   end_f = 1'b0,
    output logic                   busy
);
    logic [7:0] left  = 8'h00;
    logic [7:0] total = 8'h00;

    assign busy = valid || (left != 8'h00);

    // ---------------------------------------------------------------
    // word sequencer
    // ---------------------------------------------------------------
    // a refused word is held as it is; idle lines toggle so no stale
    // value can pass for a real word
    always @(posedge clk) begin
        if (!rst_n) begin
            valid   <= 1'b0;
            begin_f <= 1'b0;
            end_f   <= 1'b0;
            left    <= 8'h00;
        end else if (start) begin
            left  <= len;
            total <= len;
        end else if (!valid || ready) begin
            valid   <= left != 8'h00;
            begin_f <= (left == total) && (left != 8'h00);
            end_f   <= left == 8'h01;
            sync    <= (left == 8'h01) ? 8'h00 :
                       (left != 8'h00) ? tag : ~sync;
            data    <= (left != 8'h00) ? {56'h0, left} : ~data;
            if (left != 8'h00) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/ssb_source_props.sv ----
// checker: concurrent assertions on the stream source top ports
`timescale 1ns/10ps
`default_nettype none
module ssb_source_props
    import ssb_pkg::*;
(
    input wire logic             SYS_CLK,
    input wire logic             RST_N,
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PWRITE,
    input wire logic [11:0]      PADDR,
    input wire logic [31:0]      PWDATA,
    input wire logic             VALID,
    input wire logic             BURST_BEGIN_FLAG,
    input wire logic             SEU_CORRECTED,
    input wire logic             SEU_UNCORRECTED,
    input wire logic             READY,
    input wire logic             LINK_UP,
    input wire logic [ERR_W-1:0] ERROR,
    input wire logic             ERR_INTERRUPT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    logic wr;
    logic up_wr;
    logic bb_acc;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    assign wr     = PSEL && PENABLE && PWRITE;
    assign up_wr  = wr && (PADDR == REG_CTRL) && PWDATA[CTRL_LINK_UP];
    assign bb_acc = VALID && READY && BURST_BEGIN_FLAG;

    ready_needs_link_a: assert property (READY |-> LINK_UP)
        else $error("ready high while link is down");
    link_up_cause_a: assert property ($rose(LINK_UP) |->
        $past(up_wr) || $past(up_wr, 2))
        else $error("link up rose without a control write");
    ovf_cause_a: assert property (ERROR[ERR_OVF] |->
        $past(VALID) || $past(VALID, 2))
        else $error("overflow flag without a write attempt");
    seu_fix_a: assert property (ERROR[ERR_SEU_C] |->
        $past(SEU_CORRECTED) || $past(SEU_CORRECTED, 2))
        else $error("corrected upset flag without an event");
    seu_bad_a: assert property (ERROR[ERR_SEU_U] |->
        $past(SEU_UNCORRECTED) || $past(SEU_UNCORRECTED, 2))
        else $error("uncorrected upset flag without an event");
    gap_flag_a: assert property (ERROR[ERR_GAP] |->
        $past(bb_acc) || $past(bb_acc, 2))
        else $error("gap flag not at a burst start");
    irq_rise_a: assert property ($rose(ERR_INTERRUPT) |->
        (ERROR != 4'h0) || $past(wr && PADDR == REG_ERR_EN))
        else $error("interrupt rose without error or enable");
    irq_fall_a: assert property ($fell(ERR_INTERRUPT) |->
        $past(wr && (PADDR == REG_ERR_STAT || PADDR == REG_ERR_EN)))
        else $error("interrupt fell without a clear");
endmodule
bind ssb_source ssb_source_props chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .VALID(VALID), .BURST_BEGIN_FLAG(BURST_BEGIN_FLAG),
    .SEU_CORRECTED(SEU_CORRECTED), .SEU_UNCORRECTED(SEU_UNCORRECTED),
    .READY(READY), .LINK_UP(LINK_UP), .ERROR(ERROR),
    .ERR_INTERRUPT(ERR_INTERRUPT));
`default_nettype wire

// ---- tb/ssb_source_test.sv ----
// testbench: register, stream and error checks of the stream source
`timescale 1ns/10ps
`default_nettype none
module ssb_source_test;
    import ssb_pkg::*;
    logic SYS_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, start = 1'b0, CRC_ERROR_INJECT = 1'b0;
    logic SEU_CORRECTED = 1'b0, SEU_UNCORRECTED = 1'b0, LINK_TAKE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, LINK_CRC, q, c0, end_word;
    logic [7:0] len = 8'h00, tag = 8'h00, LINK_TAG, last_tag;
    logic [DATA_W-1:0] DATA, LINK_DATA;
    logic [TAG_W-1:0] SYNC;
    logic [ERR_W-1:0] ERROR;
    logic PREADY, PSLVERR, VALID, BB, BE, READY, LINK_UP, ERR_INTERRUPT;
    logic LINK_BEGIN, LINK_END, LINK_VALID, busy, e;
    int errors = 0, n_tests = 0, n_link = 0, i;

    always #5 SYS_CLK = ~SYS_CLK;

    ssb_source dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DATA(DATA),
        .SYNC(SYNC), .VALID(VALID), .BURST_BEGIN_FLAG(BB),
        .BURST_END_FLAG(BE), .CRC_ERROR_INJECT(CRC_ERROR_INJECT),
        .SEU_CORRECTED(SEU_CORRECTED), .SEU_UNCORRECTED(SEU_UNCORRECTED),
        .READY(READY), .LINK_UP(LINK_UP), .ERROR(ERROR),
        .ERR_INTERRUPT(ERR_INTERRUPT), .LINK_TAKE(LINK_TAKE),
        .LINK_DATA(LINK_DATA), .LINK_TAG(LINK_TAG), .LINK_BEGIN(LINK_BEGIN),
        .LINK_END(LINK_END), .LINK_VALID(LINK_VALID), .LINK_CRC(LINK_CRC));
    ssb_user_model usr (.clk(SYS_CLK), .rst_n(RST_N), .start(start),
        .len(len), .tag(tag), .ready(READY), .data(DATA), .sync(SYNC),
        .valid(VALID), .begin_f(BB), .end_f(BE), .busy(busy));

    // link side monitor: counts words and keeps the opening tag
    always @(posedge SYS_CLK) begin
        if (LINK_VALID === 1'b1) begin
            n_link++;
            if (LINK_BEGIN === 1'b1) last_tag = LINK_TAG;
            if (LINK_END === 1'b1) end_word = LINK_DATA[31:0];
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // setup, then access held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        // start on an edge so no request is launched off a #1 sample
        @(posedge SYS_CLK);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge SYS_CLK);
            if (PREADY === 1'b1) break;
        end
        if (k == 50) begin errors++; give_verdict(); end
        q = PRDATA; e = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    // bounded wait until the user model has sent everything
    task automatic idle_wait();
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge SYS_CLK);
        if (i == 300) begin errors++; give_verdict(); end
    endtask
    task automatic burst(input logic [7:0] n, input logic [7:0] t);
        @(posedge SYS_CLK);
        len <= n; tag <= t; start <= 1'b1;
        @(posedge SYS_CLK);
        start <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        @(posedge SYS_CLK);
        #1 cmp(READY, 0);
        cmp(LINK_UP, 0);
        apb(1'b0, REG_CTRL, 32'h0); cmp(q, CTRL_RST);
        apb(1'b0, REG_ERR_EN, 32'h0); cmp(q, {28'h0, ERR_EN_RST});
        apb(1'b0, 12'h040, 32'h0); cmp(q, 32'h0);
        cmp({31'h0, e}, 32'h1);
        // link up, burst mode, ecc and injection on, gap of two
        apb(1'b1, REG_CTRL, 32'h0000_020f);
        repeat (3) @(posedge SYS_CLK);
        #1 cmp(LINK_UP, 1);
        cmp(READY, 1);
        // link stalls: the fifo fills to partial full and ready drops
        burst(8'd14, 8'h5a);
        for (i = 0; i < 100 && READY !== 1'b0; i++) @(posedge SYS_CLK);
        cmp(READY, 0);
        LINK_TAKE <= 1'b1;
        idle_wait();
        repeat (40) @(posedge SYS_CLK);
        cmp(n_link, 14);
        cmp(last_tag, 8'h5a);
        cmp(end_word, 32'h1);
        // a far too long gap before the next burst
        apb(1'b1, REG_ERR_STAT, 32'hf);
        repeat (20) @(posedge SYS_CLK);
        burst(8'd2, 8'h33);
        idle_wait();
        repeat (5) @(posedge SYS_CLK);
        apb(1'b0, REG_ERR_STAT, 32'h0); cmp(q[3], 1);
        // upset events, then enable both and clear one at a time
        SEU_CORRECTED <= 1'b1; SEU_UNCORRECTED <= 1'b1;
        @(posedge SYS_CLK);
        SEU_CORRECTED <= 1'b0; SEU_UNCORRECTED <= 1'b0;
        #1 cmp(ERROR, 32'h6);
        repeat (3) @(posedge SYS_CLK);
        apb(1'b0, REG_ERR_STAT, 32'h0); cmp(q[2:1], 2'b11);
        apb(1'b1, REG_ERR_EN, 32'h6);
        #1 cmp(ERR_INTERRUPT, 1);
        apb(1'b1, REG_ERR_STAT, 32'h2);
        #1 cmp(ERR_INTERRUPT, 1);
        apb(1'b1, REG_ERR_STAT, 32'h4);
        #1 cmp(ERR_INTERRUPT, 0);
        // injection flips the check value while the link is quiet
        c0 = LINK_CRC;
        @(posedge SYS_CLK);
        CRC_ERROR_INJECT <= 1'b1;
        @(posedge SYS_CLK);
        #1 cmp(LINK_CRC, c0 ^ CRC_FLIP);
        // injection disarmed: the same request must leave the value alone
        apb(1'b1, REG_CTRL, 32'h0000_0205);
        #1 cmp(LINK_CRC, c0);
        // continuous mode: one stream, gap not judged, closing end taken
        apb(1'b1, REG_ERR_STAT, 32'hf);
        burst(8'd3, 8'h44);
        idle_wait();
        repeat (10) @(posedge SYS_CLK);
        cmp(n_link, 19);
        cmp(last_tag, 8'h44);
        cmp(end_word, 32'h1);
        apb(1'b0, REG_ERR_STAT, 32'h0); cmp(q, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
